// [hw/cco_core.sv]
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cco_core
	import cco_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] busAddr,
	input wire logic [DATA_W-1:0] busWdata,
	input wire logic busWr,
	input wire logic busRd,
	output logic [DATA_W-1:0] busRdata,
	output logic [15:0] memAddr,
	output logic memReq,
	input wire logic [7:0] memRdata,
	input wire logic memAck,
	input wire logic irqPending,
	output logic irqTaken,
	output logic instrDone,
	output logic busy
);
	cco_state_e state, next_state;
	cco_kind_e kind, next_kind;
	cco_arch_s arch, next_arch;
	logic [7:0] pfx, next_pfx;
	logic [7:0] operand, next_operand;
	logic [15:0] next_memAddr;
	logic [DATA_W-1:0] next_busRdata;
	logic unsup, next_unsup;
	logic irqSeen, next_irqSeen;
	logic next_irqTaken, next_instrDone;
	logic [7:0] aluFlags;
	logic aluEqual;
	logic [15:0] ptrPair, cntPair, cntNext;

	function automatic logic [7:0] selReg(input cco_arch_s r, input logic [2:0] code);
		logic [7:0] v;
		v = RST_BYTE;
		case (code)
			REG_B: v = r.b;
			REG_C: v = r.c;
			REG_D: v = r.d;
			REG_E: v = r.e;
			REG_H: v = r.h;
			REG_L: v = r.l;
			REG_A: v = r.a;
			default: v = RST_BYTE;
		endcase
		return v;
	endfunction : selReg

	function automatic logic [15:0] dec16(input logic [15:0] v, input logic [15:0] step);
		return v - step;
	endfunction : dec16

	function automatic logic isBlockKind(input cco_kind_e k);
		return (k == K_CMP_DEC) || (k == K_CMP_DEC_REP);
	endfunction : isBlockKind

	assign ptrPair = {arch.h, arch.l};
	assign cntPair = {arch.b, arch.c};
	assign cntNext = dec16(cntPair, STEP_ONE);
	assign memReq = (state == ST_OP) || (state == ST_OP2) || (state == ST_ARG) || (state == ST_MEM);
	assign busy = (state != ST_IDLE);

	cco_flag_unit flagUnit (
		.accum(arch.a),
		.operand(operand),
		.oldFlags(arch.f),
		.isCompl(kind == K_COMPL),
		.isBlock(isBlockKind(kind)),
		.counterNext(cntNext),
		.newFlags(aluFlags),
		.equal(aluEqual)
	);

	always_comb begin
		next_state = state;
		next_kind = kind;
		next_arch = arch;
		next_pfx = pfx;
		next_operand = operand;
		next_memAddr = memAddr;
		next_unsup = unsup;
		next_irqSeen = irqSeen;
		next_irqTaken = 1'b0;
		next_instrDone = 1'b0;
		next_busRdata = busRdata;
		if (busRd) begin
			case (busAddr)
				OFF_STATUS: next_busRdata = {13'h0000, irqSeen, unsup, busy};
				OFF_ACC: next_busRdata = {8'h00, arch.a};
				OFF_FLAGS: next_busRdata = {8'h00, arch.f};
				OFF_COUNT: next_busRdata = cntPair;
				OFF_DE: next_busRdata = {arch.d, arch.e};
				OFF_PTR: next_busRdata = ptrPair;
				OFF_IDX1: next_busRdata = arch.idxFirst;
				OFF_IDX2: next_busRdata = arch.idxSecond;
				OFF_PC: next_busRdata = arch.pc;
				default: next_busRdata = 16'h0000;
			endcase
		end
		case (state)
			ST_IDLE: begin
				if (busWr) begin
					case (busAddr)
						OFF_CTRL: begin
							if (busWdata[CTRL_START]) begin
								next_state = ST_OP;
								next_memAddr = arch.pc;
								next_unsup = 1'b0;
								next_irqSeen = 1'b0;
							end
						end
						OFF_ACC: next_arch.a = busWdata[7:0];
						OFF_FLAGS: next_arch.f = busWdata[7:0];
						OFF_COUNT: {next_arch.b, next_arch.c} = busWdata;
						OFF_DE: {next_arch.d, next_arch.e} = busWdata;
						OFF_PTR: {next_arch.h, next_arch.l} = busWdata;
						OFF_IDX1: next_arch.idxFirst = busWdata;
						OFF_IDX2: next_arch.idxSecond = busWdata;
						OFF_PC: next_arch.pc = busWdata;
						default: next_state = ST_IDLE;
					endcase
				end
			end
			ST_OP: begin
				if (memAck) begin
					next_arch.pc = arch.pc + STEP_ONE;
					next_memAddr = arch.pc + STEP_ONE;
					if (memRdata == OPC_COMPL_CARRY) begin
						next_kind = K_COMPL;
						next_state = ST_EXEC;
					end else if (memRdata[7:3] == OPC_CMP_REG_HI) begin
						if (memRdata[2:0] == RSEL_MEM) begin
							next_kind = K_CMP_PTR;
							next_memAddr = ptrPair;
							next_state = ST_MEM;
						end else begin
							next_kind = K_CMP_REG;
							next_operand = selReg(arch, memRdata[2:0]);
							next_state = ST_EXEC;
						end
					end else if (memRdata == OPC_CMP_IMM) begin
						next_kind = K_CMP_IMM;
						next_state = ST_ARG;
					end else if ((memRdata == PFX_EXT) || (memRdata == PFX_IDX1)
							|| (memRdata == PFX_IDX2)) begin
						next_pfx = memRdata;
						next_state = ST_OP2;
					end else begin
						next_arch.pc = arch.pc;
						next_unsup = 1'b1;
						next_state = ST_IDLE;
					end
				end
			end
			ST_OP2: begin
				if (memAck) begin
					next_arch.pc = arch.pc + STEP_ONE;
					next_memAddr = arch.pc + STEP_ONE;
					if ((pfx == PFX_EXT) && (memRdata == OPC_CMP_DEC)) begin
						next_kind = K_CMP_DEC;
						next_memAddr = ptrPair;
						next_state = ST_MEM;
					end else if ((pfx == PFX_EXT) && (memRdata == OPC_CMP_DEC_REP)) begin
						next_kind = K_CMP_DEC_REP;
						next_memAddr = ptrPair;
						next_state = ST_MEM;
					end else if ((pfx != PFX_EXT) && (memRdata == OPC_CMP_PTR)) begin
						next_kind = K_CMP_IDX;
						next_state = ST_ARG;
					end else begin
						next_arch.pc = dec16(arch.pc, STEP_ONE);
						next_unsup = 1'b1;
						next_state = ST_IDLE;
					end
				end
			end
			ST_ARG: begin
				if (memAck) begin
					next_arch.pc = arch.pc + STEP_ONE;
					if (kind == K_CMP_IMM) begin
						next_operand = memRdata;
						next_state = ST_EXEC;
					end else begin
						next_memAddr = ((pfx == PFX_IDX1) ? arch.idxFirst : arch.idxSecond)
							+ {{8{memRdata[7]}}, memRdata};
						next_state = ST_MEM;
					end
				end
			end
			ST_MEM: begin
				if (memAck) begin
					next_operand = memRdata;
					next_state = ST_EXEC;
				end
			end
			ST_EXEC: begin
				next_arch.f = aluFlags;
				next_state = ST_IDLE;
				next_instrDone = 1'b1;
				if (isBlockKind(kind)) begin
					{next_arch.h, next_arch.l} = dec16(ptrPair, STEP_ONE);
					{next_arch.b, next_arch.c} = cntNext;
				end
				// Repeat unless match or zero count
				if ((kind == K_CMP_DEC_REP) && !aluEqual && (cntNext != RST_WORD)) begin
					next_arch.pc = dec16(arch.pc, PC_REWIND);
					next_instrDone = 1'b0;
					if (irqPending) begin
						next_irqTaken = 1'b1;
						next_irqSeen = 1'b1;
					end else begin
						next_memAddr = dec16(arch.pc, PC_REWIND);
						next_state = ST_OP;
					end
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
			kind <= K_COMPL;
			arch <= '0;
			pfx <= RST_BYTE;
			operand <= RST_BYTE;
			memAddr <= RST_WORD;
			unsup <= 1'b0;
			irqSeen <= 1'b0;
			irqTaken <= 1'b0;
			instrDone <= 1'b0;
			busRdata <= 16'h0000;
		end else begin
			state <= next_state;
			kind <= next_kind;
			arch <= next_arch;
			pfx <= next_pfx;
			operand <= next_operand;
			memAddr <= next_memAddr;
			unsup <= next_unsup;
			irqSeen <= next_irqSeen;
			irqTaken <= next_irqTaken;
			instrDone <= next_instrDone;
			busRdata <= next_busRdata;
		end
	end
endmodule : cco_core
`default_nettype wire

// [inc/cco_pkg.sv]
// Functional notes
// - Opcode 00111111 inverts the carry flag.
// - Carry complement copies old carry into half-carry, clears subtract, keeps S, Z, P/V.
// - Compares subtract operand from accumulator for flags only; accumulator unchanged.
// - Compare operand is register, immediate, pointer-pair memory or indexed memory.
// - Register compare 10111rrr; B..L are 000..101, A is 111, 110 is not a register.
// - Immediate compare 11111110 fetches its operand as second instruction byte.
// - Compare 10111110 reads memory at the pointer pair as operand.
// - Prefix 11011101 or 11111101, then 10111110, then displacement; operand at index+d.
// - Single compares set S, Z, H borrow bit 4, P/V overflow, C borrow, N set.
// - 11101101 10101001 compares with pointer-pair memory, decrements pointer and counter pairs.
// - Block compares set S, Z, H, N; P/V clear when counter reaches zero; C kept.
// - Repeating form ends on zero counter or match, else rewinds PC by two.
// - Pending interrupt may be taken between repeats; PC points at the instruction.
// - 11101101 10111001 decodes as repeating form, distinct from single form.
package cco_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	// Register map
	localparam logic [3:0] OFF_CTRL = 4'h0;
	localparam logic [3:0] OFF_STATUS = 4'h1;
	localparam logic [3:0] OFF_ACC = 4'h2;
	localparam logic [3:0] OFF_FLAGS = 4'h3;
	localparam logic [3:0] OFF_COUNT = 4'h4;
	localparam logic [3:0] OFF_DE = 4'h5;
	localparam logic [3:0] OFF_PTR = 4'h6;
	localparam logic [3:0] OFF_IDX1 = 4'h7;
	localparam logic [3:0] OFF_IDX2 = 4'h8;
	localparam logic [3:0] OFF_PC = 4'h9;
	localparam int CTRL_START = 0;
	localparam int STAT_BUSY = 0;
	localparam int STAT_UNSUP = 1;
	localparam int STAT_IRQ = 2;
	// Flag positions
	localparam int FLAG_S = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_H = 4;
	localparam int FLAG_PV = 2;
	localparam int FLAG_N = 1;
	localparam int FLAG_C = 0;
	// Opcodes
	localparam logic [7:0] OPC_COMPL_CARRY = 8'h3F;
	localparam logic [4:0] OPC_CMP_REG_HI = 5'h17;
	localparam logic [2:0] RSEL_MEM = 3'h6;
	localparam logic [7:0] OPC_CMP_IMM = 8'hFE;
	localparam logic [7:0] OPC_CMP_PTR = 8'hBE;
	localparam logic [7:0] PFX_EXT = 8'hED;
	localparam logic [7:0] PFX_IDX1 = 8'hDD;
	localparam logic [7:0] PFX_IDX2 = 8'hFD;
	localparam logic [7:0] OPC_CMP_DEC = 8'hA9;
	localparam logic [7:0] OPC_CMP_DEC_REP = 8'hB9;
	// Register select codes
	localparam logic [2:0] REG_B = 3'h0;
	localparam logic [2:0] REG_C = 3'h1;
	localparam logic [2:0] REG_D = 3'h2;
	localparam logic [2:0] REG_E = 3'h3;
	localparam logic [2:0] REG_H = 3'h4;
	localparam logic [2:0] REG_L = 3'h5;
	localparam logic [2:0] REG_A = 3'h7;
	// Reset values and steps
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] STEP_ONE = 16'h0001;
	localparam logic [15:0] PC_REWIND = 16'h0002;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OP = 3'b001,
		ST_OP2 = 3'b011,
		ST_ARG = 3'b010,
		ST_MEM = 3'b110,
		ST_EXEC = 3'b111
	} cco_state_e;

	typedef enum logic [2:0] {
		K_COMPL, K_CMP_REG, K_CMP_IMM, K_CMP_PTR, K_CMP_IDX, K_CMP_DEC, K_CMP_DEC_REP
	} cco_kind_e;

	typedef struct packed {
		logic [7:0] a;
		logic [7:0] f;
		logic [7:0] b;
		logic [7:0] c;
		logic [7:0] d;
		logic [7:0] e;
		logic [7:0] h;
		logic [7:0] l;
		logic [15:0] idxFirst;
		logic [15:0] idxSecond;
		logic [15:0] pc;
	} cco_arch_s;
endpackage : cco_pkg

// [hw/cco_flag_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module cco_flag_unit
	import cco_pkg::*;
(
	input wire logic [7:0] accum,
	input wire logic [7:0] operand,
	input wire logic [7:0] oldFlags,
	input wire logic isCompl,
	input wire logic isBlock,
	input wire logic [15:0] counterNext,
	output logic [7:0] newFlags,
	output logic equal
);
	logic [8:0] diff;
	logic [4:0] low;

	assign diff = {1'b0, accum} - {1'b0, operand};
	assign low = {1'b0, accum[3:0]} - {1'b0, operand[3:0]};
	assign equal = (diff[7:0] == 8'h00);

	always_comb begin
		newFlags = oldFlags;
		if (isCompl) begin
			newFlags[FLAG_H] = oldFlags[FLAG_C];
			newFlags[FLAG_N] = 1'b0;
			newFlags[FLAG_C] = ~oldFlags[FLAG_C];
		end else begin
			newFlags[FLAG_S] = diff[7];
			newFlags[FLAG_Z] = equal;
			newFlags[FLAG_H] = low[4];
			newFlags[FLAG_N] = 1'b1;
			if (isBlock) begin
				newFlags[FLAG_PV] = (counterNext != RST_WORD);
			end else begin
				newFlags[FLAG_PV] = (accum[7] ^ operand[7]) & (diff[7] ^ accum[7]);
				newFlags[FLAG_C] = diff[8];
			end
		end
	end
endmodule : cco_flag_unit
`default_nettype wire

// [tb/cco_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cco_mem_model (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [15:0] memAddr,
	input wire logic memReq,
	input wire logic slow,
	output logic [7:0] memRdata,
	output logic memAck
);
	logic [7:0] mem [0:65535];
	logic [1:0] wt;
	logic [7:0] pat;
	// Slow mode stalls each byte two cycles
	assign memAck = memReq && (!slow || wt == 2'h2);
	// Data not acknowledged is junk that changes every cycle
	assign memRdata = memAck ? mem[memAddr] : pat;
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			wt <= 2'h0;
			pat <= 8'h5A;
		end else begin
			pat <= ~pat ^ 8'h01;
			wt <= (memReq && !memAck) ? wt + 2'h1 : 2'h0;
		end
	end
endmodule : cco_mem_model
`default_nettype wire

// [tb/cco_core_checker.sv]
`timescale 1ns/1ps
`default_nettype none
module cco_core_checker
	import cco_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [ADDR_W-1:0] busAddr,
	input wire logic [DATA_W-1:0] busWdata,
	input wire logic busWr,
	input wire logic busRd,
	input wire logic [DATA_W-1:0] busRdata,
	input wire logic [15:0] memAddr,
	input wire logic memReq,
	input wire logic [7:0] memRdata,
	input wire logic memAck,
	input wire logic irqPending,
	input wire logic irqTaken,
	input wire logic instrDone,
	input wire logic busy
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	busy_req_a: assert property (memReq |-> busy)
		else $error("memory request while idle");
	req_hold_a: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
		else $error("memory request dropped or moved");
	start_fetch_a: assert property (busWr && busAddr == OFF_CTRL && busWdata[CTRL_START]
		&& !busy |=> memReq && busy)
		else $error("start did not fetch");
	done_pulse_a: assert property (instrDone |=> !instrDone)
		else $error("done longer than one cycle");
	done_idle_a: assert property (instrDone |-> !busy && !memReq)
		else $error("done while busy");
	irq_cause_a: assert property (irqTaken |-> $past(irqPending) && !busy && !instrDone)
		else $error("yield without pending request");
	stat_busy_a: assert property (busRd && busAddr == OFF_STATUS
		|=> busRdata[STAT_BUSY] == $past(busy))
		else $error("status busy wrong");
	unmapped_zero_a: assert property (busRd && busAddr > OFF_PC |=> busRdata == '0)
		else $error("unmapped read not zero");
endmodule : cco_core_checker
`default_nettype wire

// [tb/test_compare_carry_ops.sv]
`timescale 1ns/1ps
`default_nettype none
module test_compare_carry_ops;
	import cco_pkg::*;
	logic clock = 0;
	logic arst_n = 0;
	logic [ADDR_W-1:0] busAddr = '0;
	logic [DATA_W-1:0] busWdata = '0;
	logic busWr = 0;
	logic busRd = 0;
	logic irqPending = 0;
	logic slow = 0;
	wire logic [DATA_W-1:0] busRdata;
	wire logic [15:0] memAddr;
	wire logic [7:0] memRdata;
	wire logic memReq, memAck, irqTaken, instrDone, busy;
	int fail_count = 0;
	int num_checks = 0;
	integer seed = 32'h24DC0765;
	logic [7:0] a, f, s, ef, d;
	logic [15:0] cnt, de, ptr, idxA, idxB, pc, len, j, t;
	always #2 clock = ~clock;
	cco_core cco_core_inst (.clock(clock), .arst_n(arst_n), .busAddr(busAddr),
		.busWdata(busWdata), .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
		.memAddr(memAddr), .memReq(memReq), .memRdata(memRdata), .memAck(memAck),
		.irqPending(irqPending), .irqTaken(irqTaken), .instrDone(instrDone), .busy(busy));
	cco_mem_model cco_mem_model_inst (.clock(clock), .arst_n(arst_n), .memAddr(memAddr),
		.memReq(memReq), .slow(slow), .memRdata(memRdata), .memAck(memAck));
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (e !== g) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : print_verdict
	task automatic wr(input logic [3:0] ad, input logic [15:0] dt);
		@(posedge clock);
		busWr <= 1;
		busAddr <= ad;
		busWdata <= dt;
		@(posedge clock);
		busWr <= 0;
	endtask : wr
	task automatic rc(input string n, input logic [3:0] ad, input logic [15:0] e);
		@(posedge clock);
		busRd <= 1;
		busAddr <= ad;
		@(posedge clock);
		busRd <= 0;
		#1 chk(n, e, busRdata);
	endtask : rc
	task automatic pm(input logic [15:0] ad, input logic [7:0] v);
		cco_mem_model_inst.mem[ad] = v;
	endtask : pm
	function automatic logic [7:0] cpf(input logic [7:0] x, input logic [7:0] y,
		input logic [7:0] fo, input bit isBlk, input logic [15:0] cn);
		logic [8:0] r;
		r = {1'b0, x} - {1'b0, y};
		cpf = {r[7], r[7:0] == 8'h00, fo[5], x[3:0] < y[3:0], fo[3],
			isBlk ? cn != 16'h0 : (x[7] != y[7]) && (r[7] != x[7]), 1'b1, isBlk ? fo[0] : r[8]};
	endfunction : cpf
	task automatic rnd();
		a = 8'($random(seed));
		f = 8'($random(seed));
		cnt = 16'($random(seed));
		de = 16'($random(seed));
		// Index bases kept clear of the code and pointer areas
		idxA = {4'h4, 12'($random(seed))};
		idxB = ~idxA;
		ptr = {4'h8, 12'($random(seed))};
		pc = 16'h0100;
		slow <= 1'($random(seed));
	endtask : rnd
	task automatic ld();
		wr(OFF_ACC, {8'h00, a});
		wr(OFF_FLAGS, {8'h00, f});
		wr(OFF_COUNT, cnt);
		wr(OFF_DE, de);
		wr(OFF_PTR, ptr);
		wr(OFF_IDX1, idxA);
		wr(OFF_IDX2, idxB);
		wr(OFF_PC, pc);
	endtask : ld
	task automatic run(output logic q);
		int i;
		wr(OFF_CTRL, 16'h0001);
		for (i = 0; i < 3000; i++) begin
			@(posedge clock);
			#1;
			if (instrDone === 1'b1 || irqTaken === 1'b1) break;
		end
		q = irqTaken;
		if (i == 3000) begin
			fail_count++;
			print_verdict();
		end
		chk("done", {15'h0, !q}, {15'h0, instrDone});
	endtask : run
	task automatic fin(input logic [15:0] e);
		rc("acc", OFF_ACC, {8'h00, a});
		rc("flags", OFF_FLAGS, {8'h00, ef});
		rc("counter", OFF_COUNT, cnt);
		rc("pointer", OFF_PTR, ptr);
		rc("pc", OFF_PC, e);
	endtask : fin
	task automatic blk();
		s = cco_mem_model_inst.mem[ptr];
		ptr = ptr - 16'h1;
		cnt = cnt - 16'h1;
		ef = cpf(a, s, f, 1, cnt);
	endtask : blk
	initial begin
		logic q;
		int k;
		repeat (20) @(posedge clock);
		arst_n <= 1;
		rc("pc", OFF_PC, 16'h0);
		rc("unmapped", 4'hF, 16'h0);
		rc("ctrl", OFF_CTRL, 16'h0);
		for (k = 0; k < 2; k++) begin
			rnd();
			pm(pc, OPC_COMPL_CARRY);
			ld();
			run(q);
			ef = {f[7:5], f[0], f[3:2], 1'b0, ~f[0]};
			fin(pc + 16'h1);
		end
		for (k = 0; k < 12; k++) begin
			if (k == 6) continue;
			rnd();
			d = 8'($random(seed));
			s = k == 7 ? a : k < 6 ? 8'({cnt, de, ptr} >> (40 - 8 * k)) : 8'($random(seed));
			len = k < 8 || k == 9 ? 16'h1 : k == 8 ? 16'h2 : 16'h3;
			t = (k == 10 ? idxA : idxB) + {{8{d[7]}}, d};
			if (k < 8) pm(pc, {OPC_CMP_REG_HI, 3'(k)});
			else if (k == 8) pm(pc, OPC_CMP_IMM);
			else if (k == 9) pm(pc, OPC_CMP_PTR);
			else pm(pc, k == 10 ? PFX_IDX1 : PFX_IDX2);
			pm(pc + 16'h1, k == 8 ? s : OPC_CMP_PTR);
			pm(pc + 16'h2, d);
			if (k > 9) pm(t, s);
			if (k == 9) pm(ptr, s);
			ld();
			run(q);
			ef = cpf(a, s, f, 0, 16'h0);
			fin(pc + len);
		end
		for (k = 0; k < 5; k++) begin
			rnd();
			cnt = k == 0 ? 16'h1 : 16'h4;
			pm(pc, PFX_EXT);
			pm(pc + 16'h1, k < 2 ? OPC_CMP_DEC : OPC_CMP_DEC_REP);
			for (j = 0; j < 4; j++) pm(ptr - j, (k == 2 && j == 1) ? a : a + 8'(j) + 8'h01);
			@(posedge clock);
			irqPending <= k == 4;
			ld();
			run(q);
			chk("yield", {15'h0, k == 4}, {15'h0, q});
			if (k == 4) begin
				rc("status", OFF_STATUS, 16'h0004);
				blk();
				fin(pc);
				@(posedge clock);
				irqPending <= 0;
				run(q);
			end
			if (k < 2) blk();
			else do blk(); while (s != a && cnt != 16'h0);
			fin(pc + 16'h2);
		end
		// Extended prefix with an undecoded second byte
		rnd();
		pm(pc, PFX_EXT);
		pm(pc + 16'h1, 8'hA1);
		ld();
		wr(OFF_CTRL, 16'h0001);
		for (k = 0; k < 100; k++) begin
			@(posedge clock);
			#1;
			if (busy === 1'b0) break;
		end
		if (k == 100) begin
			fail_count++;
			print_verdict();
		end
		rc("status", OFF_STATUS, 16'h0002);
		rc("pc", OFF_PC, pc);
		print_verdict();
	end
endmodule : test_compare_carry_ops
bind cco_core cco_core_checker cco_core_checker_inst (.clock(clock), .arst_n(arst_n),
	.busAddr(busAddr), .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
	.busRdata(busRdata), .memAddr(memAddr), .memReq(memReq), .memRdata(memRdata),
	.memAck(memAck), .irqPending(irqPending), .irqTaken(irqTaken),
	.instrDone(instrDone), .busy(busy));
`default_nettype wire
